// ===== gra_host.sv
// Host bus controller model: clock idles high, data pulled low only.
// Assumes a pull-up on the data line in the bench.
`timescale 1ns/100ps
`default_nettype none
module gra_host (
  // Bus pins
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  localparam int Q = 625;
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic bitx(input logic d, output logic r);
    sda_pull = ~d;
    #Q scl = 1'b1;
    #Q r = sda;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic start();
    sda_pull = 1'b0;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #Q scl = 1'b1;
    #Q sda_pull = 1'b0;
    #Q;
  endtask
  task automatic xfer(input logic [7:0] d, input logic ai, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ai, a);
  endtask
endmodule
`default_nettype wire

// ===== gra_link.sv
// Link-clock side: samples the data line on each rising edge of the bus clock.
// Assumes the bus clock stops between frames; the toggle marks each new bit.
`timescale 1ns/100ps
`default_nettype none
module gra_link (
  // Link clock and reset
  input  wire logic scl,
  input  wire logic srst,
  // Data line
  input  wire logic sda_in,
  // Sampled bit and its event toggle
  output logic      bit_r,
  output logic      tog_r
);
  typedef struct packed {
    logic smp;
    logic tog;
  } gra_link_s;

  gra_link_s st_r;
  gra_link_s st_nxt;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.smp = sda_in;
    st_nxt.tog = ~st_r.tog;
  end

  // Reset acts without the bus clock, which may be idle
  always_ff @(posedge scl or posedge srst) begin
    if (srst) begin
      st_r <= '{smp: 1'b1, tog: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bit_r = st_r.smp;
  assign tog_r = st_r.tog;
endmodule
`default_nettype wire

// ===== gra_pkg.sv
// Constants, register map and types shared by the gauge register/alert block.
// Assumes nothing beyond a SystemVerilog-2012 compiler.
package gra_pkg;

  // Register byte offsets (7-bit byte pointer space)
  localparam logic [6:0] OFF_CTRL       = 7'h00;
  localparam logic [6:0] OFF_AMPS       = 7'h04;
  localparam logic [6:0] OFF_THERM      = 7'h06;
  localparam logic [6:0] OFF_VOLTS      = 7'h08;
  localparam logic [6:0] OFF_ALARM1     = 7'h0a;
  localparam logic [6:0] OFF_ALARM2     = 7'h0c;
  localparam logic [6:0] OFF_IDENT      = 7'h0e;
  localparam logic [6:0] OFF_CHG_LEFT   = 7'h10;
  localparam logic [6:0] OFF_FULL_CAP   = 7'h12;
  localparam logic [6:0] OFF_MEAN_AMPS  = 7'h14;
  localparam logic [6:0] OFF_TO_EMPTY   = 7'h16;
  localparam logic [6:0] OFF_REVISION   = 7'h20;
  localparam logic [6:0] OFF_TUNE_A     = 7'h24;
  localparam logic [6:0] OFF_TUNE_B     = 7'h26;
  localparam logic [6:0] OFF_DIE_THERM  = 7'h28;
  localparam logic [6:0] OFF_RECHARGE   = 7'h2a;
  localparam logic [6:0] OFF_PERCENT    = 7'h2c;
  localparam logic [6:0] OFF_HEALTH     = 7'h2e;
  localparam logic [6:0] OFF_ALARM3     = 7'h30;
  localparam logic [6:0] OFF_PENDING    = 7'h36;
  localparam logic [6:0] OFF_DESIGN_CAP = 7'h3c;
  localparam logic [6:0] OFF_EXT_CMD    = 7'h3e;
  localparam logic [2:0] EXT_WIN_PAGE   = 3'h4;   // Byte pointer 0x40..0x4F
  localparam logic [6:0] OFF_PAGE_SUM   = 7'h50;
  localparam logic [6:0] OFF_MEAN_VOLTS = 7'h64;
  localparam logic [6:0] OFF_MEAN_THERM = 7'h66;
  localparam logic [6:0] OFF_TOTAL_SUM  = 7'h68;

  // Values after reset
  localparam logic [15:0] RST_CTRL       = 16'h0000;
  localparam logic [15:0] RST_THERM      = 16'h0ba6;
  localparam logic [15:0] RST_CHG_LEFT   = 16'h03e8;
  localparam logic [15:0] RST_FULL_CAP   = 16'h07d0;
  localparam logic [15:0] RST_MEAN_AMPS  = 16'h0000;
  localparam logic [15:0] RST_TO_EMPTY   = 16'hffff;
  localparam logic [15:0] RST_TUNE       = 16'h3232;
  localparam logic [15:0] RST_DIE_THERM  = 16'h0ba6;
  localparam logic [15:0] RST_RECHARGE   = 16'h0000;
  localparam logic [15:0] RST_HEALTH     = 16'h0064;
  localparam logic [15:0] RST_DESIGN_CAP = 16'h07d0;
  localparam logic [15:0] RST_EXT_CMD    = 16'h0000;
  localparam logic [7:0]  RST_EXT_BYTE   = 8'hff;
  localparam logic [15:0] RST_PAGE_SUM   = 16'hffff;
  localparam logic [15:0] RST_MEAN_VOLTS = 16'h0ed8;
  localparam logic [15:0] RST_MEAN_THERM = 16'h0ba6;
  localparam logic [15:0] RST_TOTAL_SUM  = 16'h0000;

  // Alert flag positions in alarm_bits_three and in the enable bytes
  localparam int unsigned N_ALERTS      = 9;
  localparam int unsigned FB_HOT_CHG    = 0;  // hot_while_charging
  localparam int unsigned FB_HOT_DIS    = 1;  // hot_while_discharging
  localparam int unsigned FB_OVER_V     = 2;  // over_volt_alert
  localparam int unsigned FB_UNDER_V    = 3;  // under_volt_alert
  localparam int unsigned FB_LOW_CHG    = 4;  // low_charge_alert
  localparam int unsigned FB_CHG_STEP   = 5;  // charge_step_alert
  localparam int unsigned FB_EXC_CHG    = 6;  // excess_charge_amps
  localparam int unsigned FB_EXC_DIS    = 7;  // excess_discharge_amps
  localparam int unsigned FB_THERM_STEP = 8;  // thermal_step_alert
  localparam logic [8:0]  STICKY_MASK   = 9'h120;
  localparam int unsigned EN_IRQ_BYTE   = 2;  // Extension byte holding the interrupt enable

  // Link constants
  localparam logic [6:0]  TARGET_ADDR   = 7'h55;
  localparam logic [15:0] QUICK_CMD     = 16'h4000;
  localparam int unsigned CLK_KHZ       = 10000;
  localparam int unsigned LINK_MAX_KBPS = 400;
  localparam int unsigned BIT_CYCLES    = CLK_KHZ / LINK_MAX_KBPS;
  localparam logic [3:0]  BYTE_BITS     = 4'h8;
  localparam logic [3:0]  ACK_BITS      = 4'h9;

  typedef enum logic [3:0] {
    S_IDLE  = 4'b0000,
    S_ADDR  = 4'b0001,
    S_AACK  = 4'b0011,
    S_REG   = 4'b0010,
    S_RACK  = 4'b0110,
    S_WDAT  = 4'b0111,
    S_WACK  = 4'b0101,
    S_RDAT  = 4'b0100,
    S_RDACK = 4'b1100
  } gra_fsm_e;

endpackage

// ===== gra_sync.sv
// Two-flop synchroniser for pin levels and crossing toggles.
// Assumes the destination clock is clk; inputs are asynchronous to it.
`timescale 1ns/100ps
`default_nettype none
module gra_sync #(
  parameter int unsigned W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] held;
  } gra_sync_s;

  gra_sync_s st_r;
  gra_sync_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = async_in;
    st_nxt.held = st_r.meta;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{meta: INIT, held: INIT};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.held;
endmodule
`default_nettype wire

// ===== gra_top.sv
// Gauge register bank and alert logic behind a two-wire serial target.
// Assumes srst is held for at least three clk edges and alert conditions come from clk logic.
// How it works
// RULE_01 - A condition whose enable is off never sets its flag.
// RULE_02 - With the enable on, the flag sets in the cycle after the condition is seen.
// RULE_03 - Charge-step and thermal-step flags stay set until software writes them to zero, reads the pending word or turns their enable off.
// RULE_04 - A flag already set gives no new pending event when its condition repeats.
// RULE_05 - Pending bit sets and the alert pin goes low only on a flag rising with irq enable on.
// RULE_06 - Reading the pending word clears pending, releases the pin and clears the step flags.
// RULE_07 - Turning irq enable off leaves a pending bit and a low alert pin untouched.
// RULE_08 - Turning an enable off clears that condition's flag at once.
// RULE_09 - The target acknowledges only address 1010101 and ignores all others.
// RULE_10 - The target follows bus clocks up to 400 kbit/s.
// RULE_11 - Other flags clear by themselves when their condition goes away.
// RULE_12 - Writing 0x4000 to the control word pulses the quick-sense request.
// RULE_13 - Nine separate alert conditions each own a flag and an enable.
// RULE_14 - The byte pointer steps by one after every data byte read or written.
// RULE_15 - Words sit little-endian at even addresses and a read snapshots both bytes.
`timescale 1ns/100ps
`default_nettype none
module gra_top
  import gra_pkg::*;
#(
  parameter logic [15:0] IDENT_WORD    = 16'h5a5a,  // Arbitrary value
  parameter logic [15:0] REVISION_WORD = 16'h0a0b   // Arbitrary value
) (
  // System clock and reset
  input  wire logic                          clk,
  input  wire logic                          srst,
  // Serial bus
  input  wire logic                          scl,
  input  wire logic                          sda_i,
  output logic                               sda_o,
  output logic                               sda_oe_n,
  // Alert pin, open drain
  output logic                               alert_o,
  output logic                               alert_oe_n,
  // Measurements and alert conditions
  input  wire logic [15:0]                   meas_amps,
  input  wire logic [15:0]                   meas_volts,
  input  wire logic [15:0]                   meas_percent,
  input  wire logic [gra_pkg::N_ALERTS-1:0]  alert_cond,
  // Commands to the gauge core
  output logic                               quick_sense,
  output logic                               ext_cmd_stb,
  output logic [15:0]                        ext_cmd
);
  import gra_pkg::*;

  typedef struct packed {
    gra_fsm_e             fsm;
    logic [3:0]           cnt;
    logic [7:0]           sh;
    logic                 rw;
    logic                 mack;
    logic [6:0]           ptr;
    logic [15:0]          snap;
    logic                 snap_ok;
    logic                 prev_scl;
    logic                 prev_sda;
    logic                 prev_tog;
    logic [15:0]          ctrl;
    logic [15:0]          therm;
    logic [15:0]          tune_a;
    logic [15:0]          tune_b;
    logic [15:0]          recharge;
    logic [15:0][7:0]     ext;
    logic [N_ALERTS-1:0]  flags;
    logic                 irq;
    logic                 sda_oe_n;
    logic                 alert_oe_n;
    logic                 quick;
    logic [15:0]          xcmd;
    logic                 xstb;
  } gra_top_s;

  gra_top_s st_r;
  gra_top_s st_nxt;

  logic [2:0]          pins_s;
  logic                link_bit;
  logic                link_tog;
  logic                scl_s;
  logic                sda_s;
  logic                tog_s;
  logic                start_ev;
  logic                stop_ev;
  logic                scl_fall;
  logic                bit_ev;
  logic                ld;
  logic                wr_en;
  logic                rd_clr;
  logic [N_ALERTS-1:0] en;
  logic                irq_en;
  logic [N_ALERTS-1:0] set_hit;
  logic [N_ALERTS-1:0] off_hit;
  logic [N_ALERTS-1:0] new_set;
  logic [N_ALERTS-1:0] sticky_clr;
  logic [6:0]          rd_a;
  logic [15:0]         rword;
  logic [7:0]          rbyte;
  logic [6:0]          wa;
  logic [15:0]         fw;

  // Bus clock domain samples the data bit
  gra_link u_link (
    .scl    (scl),
    .srst   (srst),
    .sda_in (sda_i),
    .bit_r  (link_bit),
    .tog_r  (link_tog)
  );

  // Pins and bit toggle into the clk domain
  gra_sync #(.W(3), .INIT(3'h3)) u_sync (
    .clk      (clk),
    .srst     (srst),
    .async_in ({link_tog, sda_i, scl}),
    .sync_out (pins_s)
  );

  assign scl_s = pins_s[0];
  assign sda_s = pins_s[1];
  assign tog_s = pins_s[2];

  always_comb begin
    st_nxt      = st_r;
    st_nxt.quick = 1'b0;
    st_nxt.xstb  = 1'b0;
    st_nxt.prev_scl = scl_s;
    st_nxt.prev_sda = sda_s;
    st_nxt.prev_tog = tog_s;
    // 25 clk cycles per bit at full bus rate leave ample margin for the crossing
    start_ev = st_r.prev_scl && scl_s && st_r.prev_sda && !sda_s;  // RULE_10
    stop_ev  = st_r.prev_scl && scl_s && !st_r.prev_sda && sda_s;
    scl_fall = st_r.prev_scl && !scl_s;
    bit_ev   = tog_s ^ st_r.prev_tog;
    ld       = 1'b0;
    wr_en    = 1'b0;
    rd_clr   = 1'b0;
    // Serial protocol
    if (start_ev) begin
      st_nxt.fsm      = S_ADDR;
      st_nxt.cnt      = 4'h0;
      st_nxt.sda_oe_n = 1'b1;
    end else if (stop_ev) begin
      st_nxt.fsm      = S_IDLE;
      st_nxt.sda_oe_n = 1'b1;
    end else begin
      case (st_r.fsm)
        S_ADDR, S_REG, S_WDAT: begin
          if (bit_ev) begin
            st_nxt.sh  = {st_r.sh[6:0], link_bit};
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == BYTE_BITS) begin
            st_nxt.sda_oe_n = 1'b0;
            if (st_r.fsm == S_ADDR) begin
              if (st_r.sh[7:1] == TARGET_ADDR) begin  // RULE_09
                st_nxt.rw  = st_r.sh[0];
                st_nxt.fsm = S_AACK;
              end else begin
                st_nxt.sda_oe_n = 1'b1;
                st_nxt.fsm      = S_IDLE;
              end
            end else if (st_r.fsm == S_REG) begin
              st_nxt.ptr     = st_r.sh[6:0];
              st_nxt.snap_ok = 1'b0;
              st_nxt.fsm     = S_RACK;
            end else begin
              wr_en      = 1'b1;
              st_nxt.fsm = S_WACK;
            end
          end
        end
        S_AACK, S_RACK, S_WACK: begin
          if (bit_ev) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == ACK_BITS) begin
            st_nxt.cnt      = 4'h0;
            st_nxt.sda_oe_n = 1'b1;
            if (st_r.fsm == S_AACK && st_r.rw) begin
              ld         = 1'b1;
              st_nxt.fsm = S_RDAT;
            end else if (st_r.fsm == S_AACK) begin
              st_nxt.fsm = S_REG;
            end else begin
              st_nxt.fsm = S_WDAT;
            end
          end
        end
        S_RDAT: begin
          if (bit_ev) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (scl_fall && st_r.cnt == BYTE_BITS) begin
            st_nxt.sda_oe_n = 1'b1;
            st_nxt.fsm      = S_RDACK;
          end else if (scl_fall) begin
            st_nxt.sda_oe_n = st_r.sh[7];
            st_nxt.sh       = {st_r.sh[6:0], 1'b0};
          end
        end
        S_RDACK: begin
          if (bit_ev) begin
            st_nxt.cnt  = st_r.cnt + 4'h1;
            st_nxt.mack = !link_bit;
          end else if (scl_fall && st_r.cnt == ACK_BITS) begin
            st_nxt.cnt = 4'h0;
            if (st_r.mack) begin
              ld         = 1'b1;
              st_nxt.fsm = S_RDAT;
            end else begin
              st_nxt.fsm = S_IDLE;
            end
          end
        end
        default: begin
          st_nxt.fsm = S_IDLE;
        end
      endcase
    end
    // Read word selection
    rd_a = {st_r.ptr[6:1], 1'b0};
    if (rd_a[6:4] == EXT_WIN_PAGE) begin
      rword = {st_r.ext[{rd_a[3:1], 1'b1}], st_r.ext[{rd_a[3:1], 1'b0}]};
    end else if (rd_a == OFF_CTRL) begin
      rword = st_r.ctrl;
    end else if (rd_a == OFF_AMPS) begin
      rword = meas_amps;
    end else if (rd_a == OFF_THERM) begin
      rword = st_r.therm;
    end else if (rd_a == OFF_VOLTS) begin
      rword = meas_volts;
    end else if (rd_a == OFF_IDENT) begin
      rword = IDENT_WORD;
    end else if (rd_a == OFF_CHG_LEFT) begin
      rword = RST_CHG_LEFT;
    end else if (rd_a == OFF_FULL_CAP) begin
      rword = RST_FULL_CAP;
    end else if (rd_a == OFF_MEAN_AMPS) begin
      rword = RST_MEAN_AMPS;
    end else if (rd_a == OFF_TO_EMPTY) begin
      rword = RST_TO_EMPTY;
    end else if (rd_a == OFF_REVISION) begin
      rword = REVISION_WORD;
    end else if (rd_a == OFF_TUNE_A) begin
      rword = st_r.tune_a;
    end else if (rd_a == OFF_TUNE_B) begin
      rword = st_r.tune_b;
    end else if (rd_a == OFF_DIE_THERM) begin
      rword = RST_DIE_THERM;
    end else if (rd_a == OFF_RECHARGE) begin
      rword = st_r.recharge;
    end else if (rd_a == OFF_PERCENT) begin
      rword = meas_percent;
    end else if (rd_a == OFF_HEALTH) begin
      rword = RST_HEALTH;
    end else if (rd_a == OFF_ALARM3) begin
      rword = {7'h00, st_r.flags};
    end else if (rd_a == OFF_PENDING) begin
      rword = {15'h0000, st_r.irq};
    end else if (rd_a == OFF_DESIGN_CAP) begin
      rword = RST_DESIGN_CAP;
    end else if (rd_a == OFF_PAGE_SUM) begin
      rword = RST_PAGE_SUM;
    end else if (rd_a == OFF_MEAN_VOLTS) begin
      rword = RST_MEAN_VOLTS;
    end else if (rd_a == OFF_MEAN_THERM) begin
      rword = RST_MEAN_THERM;
    end else if (rd_a == OFF_TOTAL_SUM) begin
      rword = RST_TOTAL_SUM;
    end else begin
      rword = 16'h0000;
    end
    // Second byte of a word comes from the snapshot of the first
    if (st_r.ptr[0] && st_r.snap_ok) begin
      rword = st_r.snap;  // RULE_15
    end
    rbyte = st_r.ptr[0] ? rword[15:8] : rword[7:0];
    if (ld) begin
      st_nxt.sda_oe_n = rbyte[7];
      st_nxt.sh       = {rbyte[6:0], 1'b0};
      st_nxt.snap     = rword;
      st_nxt.snap_ok  = !st_r.ptr[0];  // RULE_15
      st_nxt.ptr      = st_r.ptr + 7'h01;  // RULE_14
      rd_clr          = (rd_a == OFF_PENDING) && !(st_r.ptr[0] && st_r.snap_ok);  // RULE_06
    end
    // Register writes, low byte at the even address
    wa = {st_r.ptr[6:1], 1'b0};
    fw = {9'h1ff, 7'h7f};
    if (wr_en) begin
      st_nxt.ptr     = st_r.ptr + 7'h01;  // RULE_14
      st_nxt.snap_ok = 1'b0;
      if (wa[6:4] == EXT_WIN_PAGE) begin
        st_nxt.ext[st_r.ptr[3:0]] = st_r.sh;
      end else if (wa == OFF_CTRL) begin
        if (st_r.ptr[0]) begin
          st_nxt.ctrl[15:8] = st_r.sh;
          st_nxt.quick      = ({st_r.sh, st_r.ctrl[7:0]} == QUICK_CMD);  // RULE_12
        end else begin
          st_nxt.ctrl[7:0] = st_r.sh;
        end
      end else if (wa == OFF_THERM) begin
        st_nxt.therm = st_r.ptr[0] ? {st_r.sh, st_r.therm[7:0]} : {st_r.therm[15:8], st_r.sh};
      end else if (wa == OFF_TUNE_A) begin
        st_nxt.tune_a = st_r.ptr[0] ? {st_r.sh, st_r.tune_a[7:0]} : {st_r.tune_a[15:8], st_r.sh};
      end else if (wa == OFF_TUNE_B) begin
        st_nxt.tune_b = st_r.ptr[0] ? {st_r.sh, st_r.tune_b[7:0]} : {st_r.tune_b[15:8], st_r.sh};
      end else if (wa == OFF_RECHARGE) begin
        st_nxt.recharge = st_r.ptr[0] ? {st_r.sh, st_r.recharge[7:0]}
                                      : {st_r.recharge[15:8], st_r.sh};
      end else if (wa == OFF_ALARM3) begin
        fw = st_r.ptr[0] ? {7'h7f, st_r.sh[0], 8'hff} : {8'hff, st_r.sh};
      end else if (wa == OFF_EXT_CMD) begin
        st_nxt.xcmd = st_r.ptr[0] ? {st_r.sh, st_r.xcmd[7:0]} : {st_r.xcmd[15:8], st_r.sh};
        st_nxt.xstb = st_r.ptr[0];
      end
    end
    // Alert flags and pending event
    en         = {st_r.ext[1][0], st_r.ext[0]};  // RULE_13
    irq_en     = st_r.ext[EN_IRQ_BYTE][0];
    set_hit    = en & alert_cond;
    off_hit    = ~en & alert_cond;
    new_set    = set_hit & ~st_r.flags;  // RULE_04
    sticky_clr = (~fw[N_ALERTS-1:0] | {N_ALERTS{rd_clr}}) & STICKY_MASK;  // RULE_03
    // Enable gates everything, a new hit wins over any clear
    st_nxt.flags = en & (alert_cond | (st_r.flags & STICKY_MASK & ~sticky_clr));  // RULE_01 RULE_02 RULE_08 RULE_11
    if (irq_en && new_set != '0) begin
      st_nxt.irq = 1'b1;  // RULE_05
    end else if (rd_clr) begin
      st_nxt.irq = 1'b0;  // RULE_06 RULE_07
    end
    st_nxt.alert_oe_n = !st_nxt.irq;  // RULE_05
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '{fsm: S_IDLE, cnt: 4'h0, sh: 8'h00, rw: 1'b0, mack: 1'b0, ptr: 7'h00,
                snap: 16'h0000, snap_ok: 1'b0, prev_scl: 1'b1, prev_sda: 1'b1,
                prev_tog: 1'b0, ctrl: RST_CTRL, therm: RST_THERM, tune_a: RST_TUNE,
                tune_b: RST_TUNE, recharge: RST_RECHARGE, ext: {16{RST_EXT_BYTE}},
                flags: '0, irq: 1'b0, sda_oe_n: 1'b1, alert_oe_n: 1'b1,
                quick: 1'b0, xcmd: RST_EXT_CMD, xstb: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sda_o       = 1'b0;
  assign alert_o     = 1'b0;
  assign sda_oe_n    = st_r.sda_oe_n;
  assign alert_oe_n  = st_r.alert_oe_n;
  assign quick_sense = st_r.quick;
  assign ext_cmd_stb = st_r.xstb;
  assign ext_cmd     = st_r.xcmd;

  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_addr_done;
    st_r.fsm == S_ADDR && scl_fall && !start_ev && !stop_ev && !bit_ev && st_r.cnt == BYTE_BITS;
  endsequence
  sequence s_quick_wr;
    wr_en && st_r.ptr == 7'h01 && {st_r.sh, st_r.ctrl[7:0]} == QUICK_CMD;
  endsequence

  property p_r01;
    (off_hit != '0) |=> ((st_r.flags & $past(off_hit)) == '0);
  endproperty
  a_r01: assert property (p_r01) else $error("flag set while disabled");  // RULE_01
  property p_r02;
    (set_hit != '0) |=> ((~st_r.flags & $past(set_hit)) == '0);
  endproperty
  a_r02: assert property (p_r02) else $error("enabled condition did not set flag");  // RULE_02
  property p_r03;
    st_r.flags[FB_CHG_STEP] && en[FB_CHG_STEP] && !sticky_clr[FB_CHG_STEP]
      |=> st_r.flags[FB_CHG_STEP];
  endproperty
  a_r03: assert property (p_r03) else $error("step flag lost without clear");  // RULE_03
  property p_r04;
    (new_set == '0) && !st_r.irq |=> !st_r.irq;
  endproperty
  a_r04: assert property (p_r04) else $error("pending raised without new flag");  // RULE_04
  property p_r05;
    (new_set != '0) && irq_en |=> st_r.irq && !alert_oe_n;
  endproperty
  a_r05: assert property (p_r05) else $error("pending or pin missed on new flag");  // RULE_05
  property p_r06;
    $fell(st_r.irq) |-> $past(rd_clr) && alert_oe_n;
  endproperty
  a_r06: assert property (p_r06) else $error("pending cleared without read");  // RULE_06
  property p_r07;
    st_r.irq && !alert_oe_n && !rd_clr |=> st_r.irq && !alert_oe_n;
  endproperty
  a_r07: assert property (p_r07) else $error("pending dropped without read");  // RULE_07
  property p_r08;
    1'b1 |=> ((st_r.flags & ~$past(en)) == '0);
  endproperty
  a_r08: assert property (p_r08) else $error("flag survives disable");  // RULE_08
  property p_r09;
    s_addr_done and (st_r.sh[7:1] != TARGET_ADDR) |=> sda_oe_n && st_r.fsm == S_IDLE;
  endproperty
  a_r09: assert property (p_r09) else $error("foreign address acknowledged");  // RULE_09
  property p_r12;
    s_quick_wr |=> quick_sense ##1 !quick_sense;
  endproperty
  a_r12: assert property (p_r12) else $error("quick sense pulse wrong");  // RULE_12
  property p_r14;
    wr_en |=> st_r.ptr == $past(st_r.ptr) + 7'h01;
  endproperty
  a_r14: assert property (p_r14) else $error("pointer did not step");  // RULE_14
endmodule
`default_nettype wire

// ===== gra_top_tb_top.sv
// Testbench of the gauge register and alert block against a small model.
// Assumes gra_host on the bus; data line has a pull-up.
`timescale 1ns/100ps
`default_nettype none
module gra_top_tb_top;
  import gra_pkg::*;
  logic        clk, srst, scl, sda_pull, sda_o, sda_oe_n, alert_o, alert_oe_n, a;
  logic        quick_sense, ext_cmd_stb, sda;
  logic [15:0] meas_percent, ext_cmd, v;
  logic [8:0]  alert_cond;
  logic [7:0]  q8;
  logic [31:0] seed;
  int          error_cnt, n_compared, cyc, qs_cnt, es_cnt, flg, pnd, en, ie;
  logic [7:0]  ra [12] = '{8'h00, 8'h06, 8'h10, 8'h12, 8'h18, 8'h24, 8'h2e, 8'h30, 8'h36,
                           8'h3c, 8'h50, 8'h66};
  logic [15:0] rv [12] = '{16'h0000, 16'h0ba6, 16'h03e8, 16'h07d0, 16'h0000, 16'h3232,
                           16'h0064, 16'h0000, 16'h0000, 16'h07d0, 16'hffff, 16'h0ba6};
  assign sda = ~sda_pull & (sda_oe_n | sda_o);
  gra_top dut (.clk, .srst, .scl, .sda_i(sda), .sda_o, .sda_oe_n, .alert_o, .alert_oe_n,
    .meas_amps(16'h0000), .meas_volts(16'h0000), .meas_percent, .alert_cond, .quick_sense,
    .ext_cmd_stb, .ext_cmd);
  gra_host host (.scl, .sda_pull, .sda);
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (quick_sense === 1'b1) qs_cnt++;
    if (ext_cmd_stb === 1'b1) es_cnt++;
    if (cyc == 60000) begin
      error_cnt++;
      summarize();
    end
  end
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wr(logic [7:0] r, logic [15:0] d);
    host.start();
    host.xfer(8'haa, 1'b1, q8, a);
    chk("ack", 16'h0000, {15'h0000, a});
    host.xfer(r, 1'b1, q8, a);
    host.xfer(d[7:0], 1'b1, q8, a);
    host.xfer(d[15:8], 1'b1, q8, a);
    host.stop();
    if (r == 8'h40) en = d[8:0];
    if (r == 8'h40) flg &= en;
    if (r == 8'h42) ie = d[0];
    if (r == 8'h30) flg &= d | ~'h120;
  endtask
  task automatic rc(logic [7:0] r, logic [15:0] e);
    host.start();
    host.xfer(8'haa, 1'b1, q8, a);
    host.xfer(r, 1'b1, q8, a);
    host.start();
    host.xfer(8'hab, 1'b1, q8, a);
    host.xfer(8'hff, 1'b0, v[7:0], a);
    host.xfer(8'hff, 1'b1, v[15:8], a);
    host.stop();
    chk($sformatf("reg_%h", r), e, v);
    if (r == 8'h36) pnd = 0;
    if (r == 8'h36) flg &= ~'h120;
    chk("alert_pin", {15'h0000, ~pnd[0]}, {15'h0000, alert_oe_n | alert_o});
  endtask
  task automatic cond(logic [8:0] c);
    int n;
    @(posedge clk) #1 alert_cond = c;
    n = en & (c | flg & 'h120);
    if (ie != 0 && (n & ~flg) != 0) pnd = 1;
    flg = n;
    repeat (4) @(posedge clk);
    chk("alert_pin", {15'h0000, ~pnd[0]}, {15'h0000, alert_oe_n | alert_o});
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {srst, meas_percent, alert_cond, seed, en, ie} = {1'b1, 25'h0, 32'h3114_4e5e, 32'h1ff, 32'h1};
    repeat (20) @(posedge clk);
    #1 srst = 1'b0;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 12; i++) rc(ra[i], rv[i]);
    $display("test reset values ended");
    host.start();
    host.xfer(8'ha8, 1'b1, q8, a);
    host.stop();
    chk("nack", 16'h0001, {15'h0000, a});
    seed = xs(seed);
    @(posedge clk) #1 meas_percent = seed[15:0];
    rc(8'h2c, meas_percent);
    wr(8'h2a, seed[31:16]);
    rc(8'h2a, seed[31:16]);
    wr(8'h00, QUICK_CMD);
    chk("quick_sense", 16'h0001, qs_cnt[15:0]);
    wr(8'h3e, seed[15:0]);
    chk("ext_cmd", seed[15:0], ext_cmd);
    chk("ext_cmd_stb", 16'h0001, es_cnt[15:0]);
    wr(8'h24, ~seed[15:0]);
    rc(8'h24, ~seed[15:0]);
    $display("test link ended");
    cond(9'h001);
    rc(8'h30, flg[15:0]);
    wr(8'h42, 16'h0000);
    chk("alert_oe_n", 16'h0000, {15'h0000, alert_oe_n});
    rc(8'h36, pnd[15:0]);
    wr(8'h42, 16'h0001);
    cond(9'h001);
    rc(8'h36, pnd[15:0]);
    cond(9'h000);
    rc(8'h30, flg[15:0]);
    cond(9'h020);
    cond(9'h000);
    rc(8'h30, flg[15:0]);
    wr(8'h30, 16'h0000);
    rc(8'h30, flg[15:0]);
    cond(9'h100);
    cond(9'h000);
    rc(8'h36, pnd[15:0]);
    rc(8'h30, flg[15:0]);
    cond(9'h002);
    wr(8'h40, 16'h01fc);
    rc(8'h30, flg[15:0]);
    rc(8'h40, 16'h01fc);
    cond(9'h003);
    rc(8'h36, pnd[15:0]);
    $display("test alerts ended");
    summarize();
  end
endmodule
`default_nettype wire
